// File: hdl/hscc_defs.vh
// constants for the high-speed channel control register block
`ifndef HSCC_DEFS_VH
`define HSCC_DEFS_VH

`define HSCC_REG_CTL        5'h1D
`define HSCC_REG_IADDR      5'h1E
`define HSCC_REG_IDATA      5'h1F
`define HSCC_EXT_TX_SEARCH  16'h8000
`define HSCC_EXT_TX_REPLACE 16'h8001
`define HSCC_EXT_RX_SEARCH  16'h8002
`define HSCC_EXT_RX_REPLACE 16'h8003

`define HSCC_CTL_RST        16'h0880
`define HSCC_IADDR_RST      16'h0000
`define HSCC_TX_SEARCH_RST  10'h2BC
`define HSCC_TX_REPLACE_RST 10'h27C
`define HSCC_RX_SEARCH_RST  10'h27C
`define HSCC_RX_REPLACE_RST 10'h2BC

`define HSCC_RXDEPTH_HI     14
`define HSCC_RXDEPTH_LO     12
`define HSCC_RXMARK_BIT     11
`define HSCC_TXDEPTH_HI     10
`define HSCC_TXDEPTH_LO     8
`define HSCC_TXMARK_BIT     7
`define HSCC_FORCE_BIT      5
`define HSCC_JOG_BIT        4
`define HSCC_ENCBYP_BIT     3
`define HSCC_DECBYP_BIT     2
`define HSCC_HYS_HI         1
`define HSCC_HYS_LO         0

`define HSCC_HYS_ETH        2'h0
`define HSCC_HYS_ONE        2'h1
`define HSCC_HYS_TWO        2'h2
`define HSCC_HYS_THREE      2'h3

`define HSCC_ALIGN_FORCED   4'h9
`define HSCC_ALIGN_LAST     4'h9
`define HSCC_PRE_ONES       6'h20
`define HSCC_ACQ_COMMAS     2'h3
`define HSCC_ETH_ERR_LIMIT  3'h4
`define HSCC_ETH_GOOD_RUN   2'h3
`define HSCC_OP_WRITE       2'h1
`define HSCC_OP_READ        2'h2
`define HSCC_HDR_LAST       4'hC
`define HSCC_DATA_LAST      4'hF

`endif

// File: hdl/hscc_regs.v
// control registers of the fast serial channel behind a clause 22 management port
`timescale 1ns/1ps
`include "hscc_defs.vh"

module hscc_regs #(
  parameter [4:0] PHY_ADDR = 5'h00
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // management pins
  input  wire        mdc,
  input  wire        mdio_in,
  output reg         mdio_out,
  output reg         mdio_oe,
  // transmit character path
  input  wire        tx_in_valid,
  input  wire [9:0]  tx_in_char,
  output reg         tx_out_valid,
  output reg  [9:0]  tx_out_char,
  // receive character path
  input  wire        rx_in_valid,
  input  wire [9:0]  rx_in_char,
  input  wire        rx_code_err,
  input  wire        rx_comma,
  output reg         rx_out_valid,
  output reg  [9:0]  rx_out_char,
  // alignment and sync
  input  wire [3:0]  sm_align_pos,
  input  wire        jog_step,
  output reg  [3:0]  align_pos,
  output reg         sync_locked,
  // configuration to the datapath
  output reg  [2:0]  fast_rx_fifo_depth,
  output reg  [2:0]  fast_tx_fifo_depth,
  output reg         rx_marker_enable,
  output reg         tx_marker_enable,
  output reg         force_byte_alignment,
  output reg         manual_alignment_step_enable,
  output reg         fast_encoder_bypass,
  output reg         fast_decoder_bypass,
  output reg  [1:0]  sync_loss_hysteresis
);

  localparam [1:0] S_PRE = 2'h0;
  localparam [1:0] S_HDR = 2'h1;
  localparam [1:0] S_TA  = 2'h2;
  localparam [1:0] S_DAT = 2'h3;
  // every control field takes its reset value from the one register reset word
  localparam [15:0] CTL_RST = `HSCC_CTL_RST;

  // reserved bit 6 is kept as plain storage; bit 15 is not stored, ignores writes and reads zero
  reg        ctl_resv6;
  reg [15:0] indirect_address_value;
  reg [9:0]  tx_search_char;
  reg [9:0]  tx_replace_char;
  reg [9:0]  rx_search_char;
  reg [9:0]  rx_replace_char;

  reg        mdc_s1;
  reg        mdc_s2;
  reg        mdc_s3;
  reg        mdio_s1;
  reg        mdio_s2;
  reg [1:0]  mstate;
  reg [5:0]  ones;
  reg [3:0]  bcnt;
  reg [12:0] hdr;
  reg [15:0] shreg;
  reg        is_read;
  reg [4:0]  reg_addr;

  reg        jog_q;
  reg [3:0]  jog_pos;
  reg [1:0]  acq_cnt;
  reg [2:0]  err_cnt;
  reg [1:0]  good_cnt;
  reg [1:0]  hys_q;

  wire       mdc_rise = mdc_s2 & ~mdc_s3;
  wire [12:0] next_hdr = {hdr[11:0], mdio_s2};
  wire [15:0] ctl_value = {1'b0, fast_rx_fifo_depth, rx_marker_enable, fast_tx_fifo_depth,
                           tx_marker_enable, ctl_resv6, force_byte_alignment,
                           manual_alignment_step_enable, fast_encoder_bypass,
                           fast_decoder_bypass, sync_loss_hysteresis};

  // extended space read; unmapped addresses read zero
  function [15:0] ext_read;
    input [15:0] a;
    begin
      case (a)
        `HSCC_EXT_TX_SEARCH:  ext_read = {6'h00, tx_search_char};
        `HSCC_EXT_TX_REPLACE: ext_read = {6'h00, tx_replace_char};
        `HSCC_EXT_RX_SEARCH:  ext_read = {6'h00, rx_search_char};
        `HSCC_EXT_RX_REPLACE: ext_read = {6'h00, rx_replace_char};
        default:              ext_read = 16'h0000;
      endcase
    end
  endfunction

  // direct clause 22 read; only the three top addresses are mapped
  function [15:0] direct_read;
    input [4:0] a;
    begin
      case (a)
        `HSCC_REG_CTL:   direct_read = ctl_value;
        `HSCC_REG_IADDR: direct_read = indirect_address_value;
        `HSCC_REG_IDATA: direct_read = ext_read(indirect_address_value);
        default:         direct_read = 16'h0000;
      endcase
    end
  endfunction

  // pins come from the station's domain, so two flops before use
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mdc_s1  <= 1'b0;
      mdc_s2  <= 1'b0;
      mdc_s3  <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
    end else begin
      mdc_s1  <= mdc;
      mdc_s2  <= mdc_s1;
      mdc_s3  <= mdc_s2;
      mdio_s1 <= mdio_in;
      mdio_s2 <= mdio_s1;
    end
  end

  // frame engine and register writes; read data changes just after each mdc rise
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mstate                       <= S_PRE;
      ones                         <= 6'h00;
      bcnt                         <= 4'h0;
      hdr                          <= 13'h0000;
      shreg                        <= 16'h0000;
      is_read                      <= 1'b0;
      reg_addr                     <= 5'h00;
      mdio_out                     <= 1'b0;
      mdio_oe                      <= 1'b0;
      fast_rx_fifo_depth           <= CTL_RST[`HSCC_RXDEPTH_HI:`HSCC_RXDEPTH_LO];
      fast_tx_fifo_depth           <= CTL_RST[`HSCC_TXDEPTH_HI:`HSCC_TXDEPTH_LO];
      rx_marker_enable             <= CTL_RST[`HSCC_RXMARK_BIT];
      tx_marker_enable             <= CTL_RST[`HSCC_TXMARK_BIT];
      ctl_resv6                    <= CTL_RST[6];
      force_byte_alignment         <= CTL_RST[`HSCC_FORCE_BIT];
      manual_alignment_step_enable <= CTL_RST[`HSCC_JOG_BIT];
      fast_encoder_bypass          <= CTL_RST[`HSCC_ENCBYP_BIT];
      fast_decoder_bypass          <= CTL_RST[`HSCC_DECBYP_BIT];
      sync_loss_hysteresis         <= CTL_RST[`HSCC_HYS_HI:`HSCC_HYS_LO];
      indirect_address_value       <= `HSCC_IADDR_RST;
      tx_search_char               <= `HSCC_TX_SEARCH_RST;
      tx_replace_char              <= `HSCC_TX_REPLACE_RST;
      rx_search_char               <= `HSCC_RX_SEARCH_RST;
      rx_replace_char              <= `HSCC_RX_REPLACE_RST;
    end else if (mdc_rise) begin
      case (mstate)
        S_PRE: begin
          mdio_oe <= 1'b0;
          if (mdio_s2) begin
            if (ones != `HSCC_PRE_ONES)
              ones <= ones + 6'h01;
          end else if (ones == `HSCC_PRE_ONES) begin
            mstate <= S_HDR;
            bcnt   <= 4'h0;
            ones   <= 6'h00;
          end else begin
            ones <= 6'h00;
          end
        end
        S_HDR: begin
          hdr  <= next_hdr;
          bcnt <= bcnt + 4'h1;
          if (bcnt == `HSCC_HDR_LAST) begin
            // start bit, opcode and address must all fit, else wait for a new preamble
            if (next_hdr[12] && next_hdr[9:5] == PHY_ADDR &&
                (next_hdr[11:10] == `HSCC_OP_READ || next_hdr[11:10] == `HSCC_OP_WRITE)) begin
              is_read  <= (next_hdr[11:10] == `HSCC_OP_READ);
              reg_addr <= next_hdr[4:0];
              shreg    <= direct_read(next_hdr[4:0]);
              mstate   <= S_TA;
              bcnt     <= 4'h0;
            end else begin
              mstate <= S_PRE;
            end
          end
        end
        S_TA: begin
          bcnt <= bcnt + 4'h1;
          if (bcnt == 4'h0) begin
            // first turnaround bit left floating, drive the second low
            mdio_oe  <= is_read;
            mdio_out <= 1'b0;
          end else begin
            mdio_out <= shreg[15];
            shreg    <= {shreg[14:0], 1'b0};
            mstate   <= S_DAT;
            bcnt     <= 4'h0;
          end
        end
        default: begin
          bcnt <= bcnt + 4'h1;
          if (is_read) begin
            mdio_out <= shreg[15];
            shreg    <= {shreg[14:0], 1'b0};
          end else begin
            shreg <= {shreg[14:0], mdio_s2};
          end
          if (bcnt == `HSCC_DATA_LAST) begin
            mstate  <= S_PRE;
            mdio_oe <= 1'b0;
            if (!is_read) begin
              case (reg_addr)
                `HSCC_REG_CTL: begin
                  fast_rx_fifo_depth           <= shreg[`HSCC_RXDEPTH_HI-1:`HSCC_RXDEPTH_LO-1];
                  rx_marker_enable             <= shreg[`HSCC_RXMARK_BIT-1];
                  fast_tx_fifo_depth           <= shreg[`HSCC_TXDEPTH_HI-1:`HSCC_TXDEPTH_LO-1];
                  tx_marker_enable             <= shreg[`HSCC_TXMARK_BIT-1];
                  ctl_resv6                    <= shreg[5];
                  force_byte_alignment         <= shreg[`HSCC_FORCE_BIT-1];
                  manual_alignment_step_enable <= shreg[`HSCC_JOG_BIT-1];
                  fast_encoder_bypass          <= shreg[`HSCC_ENCBYP_BIT-1];
                  fast_decoder_bypass          <= shreg[`HSCC_DECBYP_BIT-1];
                  sync_loss_hysteresis         <= {shreg[0], mdio_s2};
                end
                `HSCC_REG_IADDR: indirect_address_value <= {shreg[14:0], mdio_s2};
                `HSCC_REG_IDATA: begin
                  case (indirect_address_value)
                    `HSCC_EXT_TX_SEARCH:  tx_search_char  <= {shreg[8:0], mdio_s2};
                    `HSCC_EXT_TX_REPLACE: tx_replace_char <= {shreg[8:0], mdio_s2};
                    `HSCC_EXT_RX_SEARCH:  rx_search_char  <= {shreg[8:0], mdio_s2};
                    `HSCC_EXT_RX_REPLACE: rx_replace_char <= {shreg[8:0], mdio_s2};
                    default: ;
                  endcase
                end
                default: ;
              endcase
            end
          end
        end
      endcase
    end
  end

  // marker search and replace, one cycle of latency whether enabled or not
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_out_valid <= 1'b0;
      tx_out_char  <= 10'h000;
      rx_out_valid <= 1'b0;
      rx_out_char  <= 10'h000;
    end else begin
      tx_out_valid <= tx_in_valid;
      rx_out_valid <= rx_in_valid;
      if (tx_marker_enable && tx_in_char == tx_search_char)
        tx_out_char <= tx_replace_char;
      else
        tx_out_char <= tx_in_char;
      if (rx_marker_enable && rx_in_char == rx_search_char)
        rx_out_char <= rx_replace_char;
      else
        rx_out_char <= rx_in_char;
    end
  end

  // byte alignment select; jog steps wrap over the ten bit positions
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      jog_q     <= 1'b0;
      jog_pos   <= 4'h0;
      align_pos <= 4'h0;
    end else begin
      jog_q <= jog_step;
      if (manual_alignment_step_enable && jog_step && !jog_q)
        jog_pos <= (jog_pos == `HSCC_ALIGN_LAST) ? 4'h0 : jog_pos + 4'h1;
      if (!force_byte_alignment)
        align_pos <= sm_align_pos;
      else if (manual_alignment_step_enable)
        align_pos <= jog_pos;
      else
        align_pos <= `HSCC_ALIGN_FORCED;
    end
  end

  // mode change seen one cycle late; that cycle's character is not counted
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      hys_q <= CTL_RST[`HSCC_HYS_HI:`HSCC_HYS_LO];
    else
      hys_q <= sync_loss_hysteresis;
  end

  // sync monitor: three clean commas to lock, loss chosen by hysteresis field
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync_locked <= 1'b0;
      acq_cnt     <= 2'h0;
      err_cnt     <= 3'h0;
      good_cnt    <= 2'h0;
    end else if (hys_q != sync_loss_hysteresis) begin
      // a count left by another mode must not shorten the new one
      err_cnt  <= 3'h0;
      good_cnt <= 2'h0;
    end else if (rx_in_valid) begin
      if (!sync_locked) begin
        err_cnt  <= 3'h0;
        good_cnt <= 2'h0;
        if (rx_code_err)
          acq_cnt <= 2'h0;
        else if (rx_comma) begin
          if (acq_cnt == `HSCC_ACQ_COMMAS - 2'h1) begin
            sync_locked <= 1'b1;
            acq_cnt     <= 2'h0;
          end else
            acq_cnt <= acq_cnt + 2'h1;
        end
      end else if (sync_loss_hysteresis == `HSCC_HYS_ETH) begin
        // errors add, each run of four good characters takes one back
        if (rx_code_err) begin
          good_cnt <= 2'h0;
          if (err_cnt == `HSCC_ETH_ERR_LIMIT - 3'h1)
            sync_locked <= 1'b0;
          else
            err_cnt <= err_cnt + 3'h1;
        end else if (err_cnt != 3'h0) begin
          if (good_cnt == `HSCC_ETH_GOOD_RUN) begin
            good_cnt <= 2'h0;
            err_cnt  <= err_cnt - 3'h1;
          end else
            good_cnt <= good_cnt + 2'h1;
        end
      end else begin
        // adjacent-error modes; a good character restarts the run
        if (rx_code_err) begin
          if (err_cnt[1:0] == sync_loss_hysteresis - 2'h1) begin
            sync_locked <= 1'b0;
            err_cnt     <= 3'h0;
          end else
            err_cnt <= err_cnt + 3'h1;
        end else
          err_cnt <= 3'h0;
      end
    end
  end

endmodule // hscc_regs

// File: tb/hscc_regs_chk_assertions.sv
// concurrent checks on the fast channel control register ports
`timescale 1ns/1ps
module hscc_regs_chk (
  // clock and reset
  input wire       core_clk,
  input wire       rstn,
  // character paths
  input wire       tx_in_valid,
  input wire [9:0] tx_in_char,
  input wire       tx_out_valid,
  input wire [9:0] tx_out_char,
  input wire       rx_in_valid,
  input wire [9:0] rx_in_char,
  input wire       rx_code_err,
  input wire       rx_out_valid,
  input wire [9:0] rx_out_char,
  // alignment and sync
  input wire [3:0] sm_align_pos,
  input wire [3:0] align_pos,
  input wire       sync_locked,
  // configuration
  input wire       rx_marker_enable,
  input wire       tx_marker_enable,
  input wire       force_byte_alignment,
  input wire       manual_alignment_step_enable,
  input wire [1:0] sync_loss_hysteresis
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire err = rx_in_valid && rx_code_err;
  wire [1:0] hys = sync_loss_hysteresis;
  // last received character was an error; idle cycles do not break a run
  reg prev_err;
  always @(posedge core_clk or negedge rstn)
    if (!rstn) prev_err <= 1'b0;
    else if (rx_in_valid) prev_err <= rx_code_err;
  a_tx_pass:
    assert property (tx_in_valid && !tx_marker_enable |=> tx_out_char == $past(tx_in_char))
      else $error("tx char altered with marker off");
  a_path_idle:
    assert property (!tx_in_valid && !rx_in_valid |=> !tx_out_valid && !rx_out_valid)
      else $error("char out without char in");
  a_rx_pass:
    assert property (rx_in_valid && !rx_marker_enable |=> rx_out_char == $past(rx_in_char))
      else $error("rx char altered with marker off");
  a_align_follow:
    assert property (!force_byte_alignment |=> align_pos == $past(sm_align_pos))
      else $error("alignment not following sync machine");
  a_align_forced:
    assert property (force_byte_alignment && !manual_alignment_step_enable |=> align_pos == 4'h9)
      else $error("forced alignment not nine");
  a_hys_one:
    assert property (sync_locked && hys == 2'h1 && err |=> ##[0:1] !sync_locked)
      else $error("single error kept sync");
  a_hys_two:
    assert property (sync_locked && hys == 2'h2 && err ##1 err |=> ##[0:1] !sync_locked)
      else $error("two errors kept sync");
  a_hys_hold:
    assert property (sync_locked && hys == 2'h2 && err && !prev_err |=> sync_locked)
      else $error("lone error dropped sync");
  a_hys_three:
    assert property (sync_locked && hys == 2'h3 && err ##1 err ##1 err |=> ##[0:1] !sync_locked)
      else $error("three errors kept sync");
  c_lock: cover property ($rose(sync_locked));
  c_force: cover property (force_byte_alignment && !manual_alignment_step_enable);
  c_replace: cover property (tx_out_valid && tx_out_char == 10'h27C);
endmodule // hscc_regs_chk
bind hscc_regs hscc_regs_chk i_chk (.*);

// File: tb/hscc_mdio_station.sv
// management station model driving clause 22 frames
`timescale 1ns/1ps
module hscc_mdio_station (
  // clock and pins
  input  wire  core_clk,
  input  wire  mdio_in,
  output logic mdc,
  output logic sta_oe,
  output logic sta_out
);
  initial begin
    mdc = 1'b0;
    sta_oe = 1'b0;
    sta_out = 1'b1;
  end
  // ten core cycles a bit keeps mdc well below the synchroniser limit
  task bitx(input b, output s);
    begin
      @(posedge core_clk);
      sta_out <= b;
      mdc <= 1'b0;
      repeat (5) @(posedge core_clk);
      mdc <= 1'b1;
      s = mdio_in;
      repeat (4) @(posedge core_clk);
    end
  endtask
  task frame(input [1:0] op, input [4:0] ra, input [15:0] wd, output [15:0] rd);
    logic [45:0] hdr;
    logic s;
    integer i;
    begin
      rd = 16'h0000;
      hdr = {32'hFFFF_FFFF, 2'h1, op, 5'h00, ra};
      sta_oe <= 1'b1;
      for (i = 45; i >= 0; i--) bitx(hdr[i], s);
      if (op == 2'h1) begin
        bitx(1'b1, s);
        bitx(1'b0, s);
        for (i = 15; i >= 0; i--) bitx(wd[i], s);
      end else begin
        sta_oe <= 1'b0;
        bitx(1'b1, s);
        bitx(1'b1, s);
        for (i = 15; i >= 0; i--) begin
          bitx(1'b1, s);
          rd[i] = s;
        end
      end
      sta_oe <= 1'b0;
      bitx(1'b1, s);
    end
  endtask
  // address always reloaded so each data access hits the intended register
  task ext(input [1:0] op, input [15:0] ea, input [15:0] wd, output [15:0] rd);
    begin
      frame(2'h1, 5'h1E, ea, rd);
      frame(op, 5'h1F, wd, rd);
    end
  endtask
endmodule // hscc_mdio_station

// File: tb/tb_hscc_regs.sv
// self-checking bench for the fast channel control registers
`timescale 1ns/1ps
module tb_hscc_regs;
  logic core_clk = 1'b0, rstn = 1'b0, tx_in_valid = 1'b0, rx_in_valid = 1'b0;
  logic rx_code_err = 1'b0, rx_comma = 1'b0, jog_step = 1'b0;
  logic [9:0] tx_in_char = 10'h000, rx_in_char = 10'h000;
  logic [3:0] sm_align_pos = 4'h3;
  wire mdc, sta_oe, sta_out, mdio_out, mdio_oe, tx_out_valid, rx_out_valid, sync_locked;
  wire rx_marker_enable, tx_marker_enable, force_byte_alignment, manual_alignment_step_enable;
  wire fast_encoder_bypass, fast_decoder_bypass;
  wire [9:0] tx_out_char, rx_out_char;
  wire [3:0] align_pos;
  wire [2:0] fast_rx_fifo_depth, fast_tx_fifo_depth;
  wire [1:0] sync_loss_hysteresis;
  // pull-up wins when nobody drives the line
  wire mdio_in = mdio_oe ? mdio_out : (sta_oe ? sta_out : 1'b1);
  wire [15:0] cfg = {1'b0, fast_rx_fifo_depth, rx_marker_enable, fast_tx_fifo_depth,
    tx_marker_enable, 1'b0, force_byte_alignment, manual_alignment_step_enable,
    fast_encoder_bypass, fast_decoder_bypass, sync_loss_hysteresis};
  integer n_fail = 0, tests_run = 0, m, n;
  logic [15:0] rd;
  hscc_regs i_dut (.*);
  hscc_mdio_station i_sta (.*);
  initial forever #50 core_clk = ~core_clk;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      tests_run++;
      if (got !== exp) begin
        n_fail++;
        $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [4:0] ra, input [15:0] d);
    i_sta.frame(2'h1, ra, d, rd);
  endtask
  task rdc(input [4:0] ra, input [15:0] exp);
    begin
      i_sta.frame(2'h2, ra, 16'h0000, rd);
      chk(rd, exp);
    end
  endtask
  task erd(input [15:0] ea, input [15:0] exp);
    begin
      i_sta.ext(2'h2, ea, 16'h0000, rd);
      chk(rd, exp);
    end
  endtask
  task chr(input tx, input [9:0] c, input [9:0] exp);
    begin
      @(posedge core_clk);
      tx_in_valid <= tx;
      rx_in_valid <= !tx;
      tx_in_char <= c;
      rx_in_char <= c;
      @(posedge core_clk);
      tx_in_valid <= 1'b0;
      rx_in_valid <= 1'b0;
      #1 chk({5'h00, tx ? {tx_out_valid, tx_out_char} : {rx_out_valid, rx_out_char}},
             {6'h01, exp});
    end
  endtask
  // back-to-back receive characters, then the sync state once they settle
  task rxs(input [2:0] k, input err, input exp);
    integer i;
    begin
      for (i = 0; i < k; i++) begin
        @(posedge core_clk);
        rx_in_valid <= 1'b1;
        rx_comma <= !err;
        rx_code_err <= err;
      end
      @(posedge core_clk);
      rx_in_valid <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk({15'h0000, sync_locked}, {15'h0000, exp});
    end
  endtask
  task complete_run;
    begin
      if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #4_000_000;
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    #1 chk(cfg, 16'h0880);
    repeat (3) @(posedge core_clk);
    rdc(5'h1D, 16'h0880);
    rdc(5'h1E, 16'h0000);
    rdc(5'h05, 16'h0000);
    erd(16'h8000, 16'h02BC);
    erd(16'h8001, 16'h027C);
    wr(5'h1D, 16'hD329);
    rdc(5'h1D, 16'h5329);
    chk(cfg, 16'h5329);
    chk({12'h000, align_pos}, 16'h0009);
    chr(1'b1, 10'h2BC, 10'h2BC);
    chr(1'b0, 10'h27C, 10'h27C);
    i_sta.ext(2'h1, 16'h8000, 16'h0155, rd);
    wr(5'h1D, 16'h08B0);
    rdc(5'h1E, 16'h8000);
    erd(16'h8000, 16'h0155);
    chr(1'b1, 10'h155, 10'h27C);
    chr(1'b1, 10'h2BC, 10'h2BC);
    chr(1'b0, 10'h27C, 10'h2BC);
    repeat (11) begin
      @(posedge core_clk) jog_step <= 1'b1;
      repeat (3) @(posedge core_clk);
      jog_step <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    chk({12'h000, align_pos}, 16'h0001);
    wr(5'h1D, 16'h0880);
    chk({12'h000, align_pos}, 16'h0003);
    for (m = 0; m < 4; m++) begin
      n = (m == 0) ? 4 : m;
      wr(5'h1D, 16'h0880 | m[1:0]);
      rxs(3'h3, 1'b0, 1'b1);
      rxs(n[2:0] - 3'h1, 1'b1, 1'b1);
      rxs(n[2:0], 1'b1, 1'b0);
    end
    complete_run;
  end
endmodule // tb_hscc_regs
